// file: core/mbd_decoder.sv
// Two-bank memory chip-select decoder with strap registers.
// Assumes a synchronous register master and an address bus stable while decoded.
`timescale 1ns/1ps

// Function
// - A000-EFFF ROM in five 4K blocks, each strap: dedicated bank 0 or common.
// - ROM at 8000-9FFF and F000-FFFF, when enabled, answers in both banks.
// - RAM 0000-0FFF is enabled in both banks always.
// - RAM 1000-BFFF is bank 0 only with strap fitted, both banks otherwise.
// - The RAM strap comes out of reset fitted.
module mbd_decoder #(
	parameter logic BANK_ACTIVE_LOW = 1'b1
) (
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// Register port.
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Processor side.
	input  wire logic [15:0] cpu_addr,
	input  wire logic        bank_address_line,
	// Chip selects.
	output logic             rom_sel,
	output logic             ram_sel,
	output logic             bank1_active
);

	// =========================================================================
	// Strap and enable registers.
	logic [4:0] rom_block_share_straps_ff;
	logic       ram_upper_share_strap_ff;
	logic [1:0] rom_en_ff;

	// Software writes stand in for the board straps; reset gives factory setup.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rom_block_share_straps_ff <= mbd_pkg::ROM_SHARE_RST;
			ram_upper_share_strap_ff  <= mbd_pkg::RAM_STRAP_RST;
			rom_en_ff                 <= mbd_pkg::ROMEN_RST;
		end else if (reg_wr) begin
			if (reg_addr == mbd_pkg::STRAP_OFS) begin
				rom_block_share_straps_ff <= reg_wdata[mbd_pkg::ROM_BLOCKS-1:0];
				ram_upper_share_strap_ff  <= reg_wdata[mbd_pkg::RAM_STRAP_BIT];
			end
			if (reg_addr == mbd_pkg::ROMEN_OFS) begin
				rom_en_ff <= reg_wdata[1:0];
			end
		end
	end

	// =========================================================================
	// Combinational decode. Outputs are not registered on purpose: a chip
	// select must follow the address in the same cycle, so a flop would cost
	// a whole access.
	logic [3:0] blk;
	logic       bank0;
	logic [mbd_pkg::ROM_BLOCKS-1:0] shared_hit;

	assign blk          = cpu_addr[15:12];
	assign bank1_active = BANK_ACTIVE_LOW ? ~bank_address_line : bank_address_line;
	assign bank0        = ~bank1_active;

	// One enable per switchable 4K ROM block.
	genvar gi;
	generate
		for (gi = 0; gi < mbd_pkg::ROM_BLOCKS; gi++) begin : g_rom_blk
			assign shared_hit[gi] = (blk == mbd_pkg::BLK_ROM_SH0 + 4'(gi)) &&
			                        (bank0 || rom_block_share_straps_ff[gi]);
		end
	endgenerate

	// ROM select: fixed regions ignore bank and straps entirely.
	always_comb begin
		rom_sel = |shared_hit;
		if ((blk == mbd_pkg::BLK_ROM_LO0 || blk == mbd_pkg::BLK_ROM_LO1) &&
		    rom_en_ff[mbd_pkg::ROM_LO_EN_BIT]) begin
			rom_sel = 1'b1;
		end
		if (blk == mbd_pkg::BLK_ROM_HI && rom_en_ff[mbd_pkg::ROM_HI_EN_BIT]) begin
			rom_sel = 1'b1;
		end
	end

	// RAM select: the low block keeps zero page and stack visible in both banks.
	always_comb begin
		ram_sel = 1'b0;
		if (blk == mbd_pkg::BLK_RAM_LOW) begin
			ram_sel = 1'b1;
		end else if (blk <= mbd_pkg::BLK_RAM_TOP) begin
			ram_sel = bank0 || !ram_upper_share_strap_ff;
		end
	end

	// =========================================================================
	// Read port: data stand one cycle after the strobe and only then.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				mbd_pkg::STRAP_OFS:  reg_rdata <= {2'h0, ram_upper_share_strap_ff, rom_block_share_straps_ff};
				mbd_pkg::ROMEN_OFS:  reg_rdata <= {6'h00, rom_en_ff};
				mbd_pkg::STATUS_OFS: reg_rdata <= {5'h00, ram_sel, rom_sel, bank1_active};
				default:             reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// =========================================================================
	// Checks on the decode.
	a_rom_dedicated_blk: assert property (@(posedge clock) disable iff (sys_rst)
		(blk >= 4'ha && blk <= 4'he && bank1_active &&
		 !rom_block_share_straps_ff[3'(blk - 4'ha)]) |-> !rom_sel)
		else $error("Dedicated ROM block selected in bank 1.");

	a_rom_common_blk: assert property (@(posedge clock) disable iff (sys_rst)
		(blk >= 4'ha && blk <= 4'he && rom_block_share_straps_ff[3'(blk - 4'ha)]) |-> rom_sel)
		else $error("Common ROM block not selected.");

	a_rom_fixed_both: assert property (@(posedge clock) disable iff (sys_rst)
		(blk == 4'hf && rom_en_ff[1]) || ((blk == 4'h8 || blk == 4'h9) && rom_en_ff[0]) |-> rom_sel)
		else $error("Fixed ROM region not selected.");

	a_ram_low_always: assert property (@(posedge clock) disable iff (sys_rst)
		(cpu_addr < 16'h1000) |-> ram_sel && !rom_sel)
		else $error("Low RAM block not selected.");

	a_ram_upper_ded: assert property (@(posedge clock) disable iff (sys_rst)
		(blk >= 4'h1 && blk <= 4'hb) |-> (ram_sel == (!bank1_active || !ram_upper_share_strap_ff)))
		else $error("Upper RAM select wrong for bank and strap.");

	a_strap_reset_val: assert property (@(posedge clock)
		$past(sys_rst) |-> ram_upper_share_strap_ff && rom_block_share_straps_ff == 5'h00)
		else $error("Strap reset value wrong.");

	a_bank_polarity: assert property (@(posedge clock) disable iff (sys_rst)
		bank1_active == (bank_address_line ^ BANK_ACTIVE_LOW))
		else $error("Bank line polarity wrong.");

	a_bank_follows: assert property (@(posedge clock) disable iff (sys_rst)
		$changed(bank_address_line) && blk == 4'h5 && $stable(blk) && ram_upper_share_strap_ff &&
		$stable(ram_upper_share_strap_ff) |-> $changed(ram_sel))
		else $error("RAM select did not follow bank line.");

	a_read_one_cycle: assert property (@(posedge clock) disable iff (sys_rst)
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("Read data held beyond one cycle.");

	c_bank1_ram: cover property (@(posedge clock) disable iff (sys_rst) bank1_active && blk == 4'h3 && ram_sel);
	c_bank1_rom_sh: cover property (@(posedge clock) disable iff (sys_rst) bank1_active && blk == 4'hc && rom_sel);
	c_bank_switch: cover property (@(posedge clock) disable iff (sys_rst) bank0 ##1 bank1_active ##1 bank0);
	c_strap_write: cover property (@(posedge clock) disable iff (sys_rst) reg_wr && reg_addr == 4'h0);

endmodule : mbd_decoder

// file: shared/mbd_pkg.sv
// Constants for the two-bank memory decoder: register map, field positions,
// reset values and address-block codes.
// Assumes a 16-bit processor address bus decoded in 4K blocks.
package mbd_pkg;

	// =========================================================================
	// Register map (word index on the plain register port).
	localparam logic [3:0] STRAP_OFS  = 4'h0;
	localparam logic [3:0] ROMEN_OFS  = 4'h1;
	localparam logic [3:0] STATUS_OFS = 4'h2;

	// =========================================================================
	// Field positions.
	localparam int ROM_BLOCKS     = 5;
	localparam int RAM_STRAP_BIT  = 5;
	localparam int ROM_LO_EN_BIT  = 0;
	localparam int ROM_HI_EN_BIT  = 1;
	localparam int ST_BANK1_BIT   = 0;
	localparam int ST_ROM_BIT     = 1;
	localparam int ST_RAM_BIT     = 2;

	// =========================================================================
	// Reset values: ROM blocks dedicated, RAM strap fitted, both fixed ROMs on.
	localparam logic [4:0] ROM_SHARE_RST = 5'h00;
	localparam logic       RAM_STRAP_RST = 1'b1;
	localparam logic [1:0] ROMEN_RST     = 2'h3;

	// =========================================================================
	// Address block codes (upper nibble of the address).
	localparam logic [3:0] BLK_RAM_LOW  = 4'h0;
	localparam logic [3:0] BLK_RAM_TOP  = 4'hb;
	localparam logic [3:0] BLK_ROM_LO0  = 4'h8;
	localparam logic [3:0] BLK_ROM_LO1  = 4'h9;
	localparam logic [3:0] BLK_ROM_SH0  = 4'ha;
	localparam logic [3:0] BLK_ROM_HI   = 4'hf;

endpackage : mbd_pkg

// file: dv/mbd_cpu_model.sv
// Processor-side model: drives the address bus and a peripheral port.
// Assumes the bench writes the port and the address on rising clock edges.
`timescale 1ns/1ps
// ==========
// Processor model
module mbd_cpu_model (
	// Clock.
	input  wire logic        clock,
	// Bench requests.
	input  wire logic        port_wr,
	input  wire logic [7:0]  port_data,
	input  wire logic [15:0] addr_req,
	// Decoder side.
	output logic      [15:0] cpu_addr,
	output logic             bank_address_line
);
	logic [7:0] port_b_ff;
	// A port store lands at the edge, like a software write to the data register.
	always_ff @(posedge clock) begin
		if (port_wr) port_b_ff <= port_data;
		cpu_addr <= addr_req;
	end
	// The bank line is port bit two, wired straight out.
	assign bank_address_line = port_b_ff[2];
endmodule : mbd_cpu_model

// file: dv/testbench.sv
// Self-checking bench for the two-bank decoder.
// Assumes the decoder package and the processor model are compiled first.
`timescale 1ns/1ps
// ==========
// Bench top
module testbench;
	logic        clock, sys_rst, reg_wr, reg_rd, port_wr, rom_sel, ram_sel, bank1_active, bank_address_line;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, port_data, e;
	logic [15:0] addr_req, cpu_addr, seed;
	logic [5:0]  strap;
	logic [1:0]  romen;
	int          failures = 0, checked = 0, cycles = 0;
	mbd_decoder DUT (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_addr,
		.bank_address_line, .rom_sel, .ram_sel, .bank1_active);
	mbd_cpu_model CPU (.clock, .port_wr, .port_data, .addr_req, .cpu_addr, .bank_address_line);
	// Free-running clock; a hang is cut short by the cycle ceiling.
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			wrap_up();
		end
	end
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr
	// Expected selects in status layout: bit0 bank 1, bit1 ROM, bit2 RAM.
	function automatic logic [7:0] exp_dec(input logic [15:0] a, input logic b1);
		logic [3:0] k;
		logic       rom, ram;
		k = a[15:12];
		rom = (k == 4'h8 || k == 4'h9) ? romen[0] : (k == 4'hf) ? romen[1] : (k >= 4'ha) ? (!b1 || strap[k - 4'ha]) : 1'b0;
		ram = (k == 4'h0) || (k <= 4'hb && (!b1 || !strap[5]));
		return {5'h00, ram, rom, b1};
	endfunction : exp_dec
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rd
	// Set address and bank port through the model, then check selects and status.
	task automatic dec(input logic [15:0] a, input logic pb);
		@(posedge clock);
		addr_req <= a;
		port_data <= {5'h00, pb, 2'h0};
		port_wr <= 1'b1;
		@(posedge clock);
		port_wr <= 1'b0;
		@(posedge clock);
		#1;
		e = exp_dec(a, !pb);
		chk({5'h00, ram_sel, rom_sel, bank1_active}, e);
		rd(4'h2, e);
	endtask : dec
	task automatic wrap_up();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	// Reset, reset values, then random straps across every 4K block and both banks.
	initial begin
		{reg_wr, reg_rd, port_wr, reg_addr, reg_wdata, port_data, addr_req} = '0;
		sys_rst = 1'b1;
		seed = 16'hfc80;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		rd(4'h0, 8'h20);
		rd(4'h1, 8'h03);
		rd(4'h3, 8'h00);
		strap = 6'h20;
		romen = 2'h3;
		dec(16'h5123, 1'b0);
		for (int i = 0; i < 320; i++) begin
			seed = lfsr(seed);
			if (i % 16 == 0) begin
				strap = seed[5:0];
				romen = seed[7:6];
				wr(4'h0, {2'h0, strap});
				wr(4'h1, {6'h00, romen});
				rd(4'h0, {2'h0, strap});
			end
			dec({i[3:0], seed[11:0]}, seed[12]);
		end
		wrap_up();
	end
endmodule : testbench
